// File: logic/clock_select_pkg.sv
// constants, states and carriers for the system clock select and rc trim
package clock_select_pkg;

  // ----------------------------------------------------------------
  // clock and register map
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [3:0] ADDR_TRIM = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_SPAN = 4'h8;

  // ----------------------------------------------------------------
  // fuse encodings and shipped values
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_EXT = 4'h0;
  localparam logic [3:0] SRC_RC_1M = 4'h1;
  localparam logic [3:0] SRC_RC_2M = 4'h2;
  localparam logic [3:0] SRC_RC_4M = 4'h3;
  localparam logic [3:0] SRC_RC_8M = 4'h4;
  localparam logic [1:0] SUT_NONE = 2'h0;
  localparam logic [1:0] SUT_SHORT = 2'h1;
  localparam logic [1:0] SUT_LONG = 2'h2;
  localparam logic [1:0] SUT_RSVD = 2'h3;
  localparam logic [3:0] SHIP_SRC = SRC_RC_1M;
  localparam logic [1:0] SHIP_SUT = SUT_LONG;
  localparam logic SHIP_OPT = 1'b1;

  // ----------------------------------------------------------------
  // reset values, trim and signature row
  // ----------------------------------------------------------------
  localparam logic [7:0] SIG_CAL_ADDR = 8'h00;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [7:0] TRIM_MID = 8'h7f;
  localparam logic [7:0] SPAN_MIN_BASE = 8'h32;
  localparam logic [7:0] SPAN_MAX_BASE = 8'h64;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [2:0] WAKE_CYCLES = 3'h6;
  localparam int T_RST_SHORT_US = 4100;
  localparam int T_RST_LONG_US = 65000;
  localparam int WDT_TICK_NS = 1000;
  localparam int RST_SHORT_TICKS = T_RST_SHORT_US * 1000 / WDT_TICK_NS;
  localparam int RST_LONG_TICKS = T_RST_LONG_US * 1000 / WDT_TICK_NS;
  localparam int DLY_W = 17;

  // ----------------------------------------------------------------
  // status word bit positions
  // ----------------------------------------------------------------
  localparam int ST_RC_BIT = 6;
  localparam int ST_EXT_BIT = 7;
  localparam int ST_READY_BIT = 8;
  localparam int ST_RSVD_BIT = 9;
  localparam int ST_DLY_BIT = 10;
  localparam int ST_OPT_BIT = 11;

  typedef enum logic [2:0] {
    ST_LOAD_REQ = 3'b000,
    ST_LOAD_WAIT = 3'b001,
    ST_RST_DELAY = 3'b011,
    ST_RUN = 3'b010,
    ST_WAKE = 3'b110
  } state_e;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avl_req_s;

  typedef struct packed {
    logic [3:0] src;
    logic [1:0] startup_time_fuses;
    logic opt;
  } fuse_s;

  typedef struct packed {
    logic busy;
    logic [DLY_W-1:0] rem;
    logic done;
  } dly_state_s;

  typedef struct packed {
    state_e state;
    logic [7:0] trim;
    fuse_s fuse;
    logic rc_sel;
    logic ext_sel;
    logic [3:0] nominal_mhz;
    logic pins_free;
    logic nvm_rc;
    logic clk_ready;
    logic dly_start;
    logic [2:0] wake_cnt;
    logic sig_rd;
    logic waitreq;
    logic [31:0] rdata;
  } top_state_s;

endpackage : clock_select_pkg

// File: logic/tick_delay.sv
// reset delay counter advanced by watchdog oscillator ticks
`timescale 1ns/1ps
`default_nettype none
module tick_delay
  import clock_select_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic start,
  input wire logic tick,
  input wire logic [DLY_W-1:0] limit,
  output logic busy,
  output logic done
);
  dly_state_s q, d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    if (start) begin
      d.busy = 1'b1;
      d.rem = limit;
    end else if (q.busy) begin
      if (q.rem == '0) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end else if (tick) begin
        d.rem = q.rem - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign busy = q.busy;
  assign done = q.done;
endmodule : tick_delay
`default_nettype wire

// File: logic/trim_span.sv
// percent of nominal frequency reached at a trim value, given the base
`timescale 1ns/1ps
`default_nettype none
module trim_span
  import clock_select_pkg::*;
#(
  parameter logic [7:0] BASE = SPAN_MIN_BASE
) (
  input wire logic [7:0] trim,
  output logic [7:0] pct
);
  logic [15:0] step;
  logic [15:0] sum;

  // two linear pieces meeting at the midpoint code
  always_comb begin
    step = 16'h0;
    sum = 16'h0;
    if (trim <= TRIM_MID) begin
      step = 16'(trim) * 16'(BASE >> 1) / 16'(TRIM_MID);
      sum = 16'(BASE) + step;
    end else begin
      step = 16'(trim - TRIM_MID) * 16'(BASE >> 1) / 16'h80;
      sum = 16'(BASE) + 16'(BASE >> 1) + step;
    end
    pct = sum[7:0];
  end
endmodule : trim_span
`default_nettype wire

// File: logic/clock_select_top.sv
// system clock source select, start-up timing and rc trim register
// ----------------------------------------------------------------
// Operation
// - rc source on select codes 1..4
// - shipped fuses: 1 MHz rc, slow power
// - reset copies factory trim byte automatically
// - trim byte from signature row high byte
// - rc start-up: six cycles, reset delay options
// - reset delay counted on watchdog oscillator
// - frequency rises with trim value
// - trim 00/7f/ff span table of percents
// - nvm timing follows calibrated rc oscillator when rc selected
// - oscillator pins free when rc selected
// - external clock on select code 0000
// - external start-up: six cycles, reset delay
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module clock_select_top
  import clock_select_pkg::*;
#(
  parameter int RST_SHORT_CNT = RST_SHORT_TICKS,
  parameter int RST_LONG_CNT = RST_LONG_TICKS
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire avl_req_s avl_req,
  output logic avl_waitrequest,
  output logic [31:0] avl_readdata,
  input wire fuse_s fuses,
  input wire logic fuses_blank,
  input wire logic wdt_tick,
  input wire logic wake_req,
  output logic sig_rd,
  output logic [7:0] sig_addr,
  input wire logic sig_rvalid,
  input wire logic [15:0] sig_rdata,
  output logic [7:0] rc_trim,
  output logic rc_select,
  output logic ext_clk_select,
  output logic [3:0] nominal_mhz,
  output logic osc_pins_free,
  output logic nvm_timing_rc,
  output logic clk_ready
);

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  top_state_s q, d;
  fuse_s fuse_eff;
  logic [DLY_W-1:0] dly_limit;
  logic dly_busy;
  logic dly_done;
  logic [7:0] span_min;
  logic [7:0] span_max;
  logic loading;
  logic bus_req;
  logic [31:0] status_word;

  assign loading = (q.state == ST_LOAD_REQ) || (q.state == ST_LOAD_WAIT);
  assign bus_req = avl_req.read || avl_req.write;

  // blank fuse array reads as the shipped setting
  assign fuse_eff = fuses_blank ? fuse_s'({SHIP_SRC, SHIP_SUT, SHIP_OPT})
                                : fuses;

  // extra reset delay per start-up code, reserved gives none
  always_comb begin
    unique case (q.fuse.startup_time_fuses)
      SUT_SHORT: dly_limit = DLY_W'(RST_SHORT_CNT);
      SUT_LONG: dly_limit = DLY_W'(RST_LONG_CNT);
      SUT_NONE, SUT_RSVD: dly_limit = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // reset delay on watchdog ticks and trim span estimate
  // ----------------------------------------------------------------
  tick_delay u_rst_delay (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .start(q.dly_start),
    .tick(wdt_tick),
    .limit(dly_limit),
    .busy(dly_busy),
    .done(dly_done)
  );

  trim_span #(.BASE(SPAN_MIN_BASE)) u_span_min (
    .trim(q.trim),
    .pct(span_min)
  );

  trim_span #(.BASE(SPAN_MAX_BASE)) u_span_max (
    .trim(q.trim),
    .pct(span_max)
  );

  always_comb begin
    status_word = 32'h0;
    status_word[3:0] = q.fuse.src;
    status_word[5:4] = q.fuse.startup_time_fuses;
    status_word[ST_RC_BIT] = q.rc_sel;
    status_word[ST_EXT_BIT] = q.ext_sel;
    status_word[ST_READY_BIT] = q.clk_ready;
    status_word[ST_RSVD_BIT] = (q.fuse.startup_time_fuses == SUT_RSVD);
    status_word[ST_DLY_BIT] = dly_busy;
    status_word[ST_OPT_BIT] = q.rc_sel && !q.fuse.opt;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.dly_start = 1'b0;

    unique case (q.state)
      ST_LOAD_REQ: begin
        d.fuse = fuse_eff;
        d.sig_rd = 1'b1;
        d.state = ST_LOAD_WAIT;
      end
      ST_LOAD_WAIT: begin
        if (sig_rvalid) begin
          d.trim = sig_rdata[15:8];
          d.sig_rd = 1'b0;
          d.dly_start = 1'b1;
          d.state = ST_RST_DELAY;
        end
      end
      ST_RST_DELAY: begin
        if (dly_done) begin
          d.clk_ready = 1'b1;
          d.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (wake_req) begin
          d.clk_ready = 1'b0;
          d.wake_cnt = 3'h0;
          d.state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        d.wake_cnt = q.wake_cnt + 3'h1;
        if (q.wake_cnt == WAKE_CYCLES - 3'h1) begin
          d.clk_ready = 1'b1;
          d.state = ST_RUN;
        end
      end
      default: begin
        d.state = ST_LOAD_REQ;
      end
    endcase

    // source decode from the latched fuses
    d.rc_sel = (q.fuse.src >= SRC_RC_1M) && (q.fuse.src <= SRC_RC_8M);
    d.ext_sel = (q.fuse.src == SRC_EXT);
    d.pins_free = d.rc_sel;
    d.nvm_rc = d.rc_sel;
    unique case (q.fuse.src)
      SRC_RC_1M: d.nominal_mhz = 4'h1;
      SRC_RC_2M: d.nominal_mhz = 4'h2;
      SRC_RC_4M: d.nominal_mhz = 4'h4;
      SRC_RC_8M: d.nominal_mhz = 4'h8;
      default: d.nominal_mhz = 4'h0;
    endcase

    // bus slave: answer one cycle after the request is seen
    if (!q.waitreq) begin
      d.waitreq = 1'b1;
      if (avl_req.write && avl_req.address == ADDR_TRIM &&
          avl_req.byteenable[0]) begin
        d.trim = avl_req.writedata[7:0];
      end
    end else if (bus_req && !loading) begin
      d.waitreq = 1'b0;
      d.rdata = 32'h0;
      if (avl_req.read) begin
        unique case (avl_req.address)
          ADDR_TRIM: d.rdata = {24'h0, q.trim};
          ADDR_STATUS: d.rdata = status_word;
          ADDR_SPAN: d.rdata = {16'h0, span_max, span_min};
          default: d.rdata = 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      q <= '0;
      q.state <= ST_LOAD_REQ;
      q.trim <= TRIM_RESET;
      q.fuse <= fuse_s'({SHIP_SRC, SHIP_SUT, SHIP_OPT});
      q.waitreq <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avl_waitrequest = q.waitreq;
  assign avl_readdata = q.rdata;
  assign sig_rd = q.sig_rd;
  assign sig_addr = SIG_CAL_ADDR;
  assign rc_trim = q.trim;
  assign rc_select = q.rc_sel;
  assign ext_clk_select = q.ext_sel;
  assign nominal_mhz = q.nominal_mhz;
  assign osc_pins_free = q.pins_free;
  assign nvm_timing_rc = q.nvm_rc;
  assign clk_ready = q.clk_ready;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst || !clk_en);

  sequence s_wake_hold;
    !q.clk_ready [*6];
  endsequence

  sequence s_wake_done;
    q.clk_ready && q.state == ST_RUN;
  endsequence

  a_trim_reset_load: assert property (
    q.state == ST_LOAD_WAIT && sig_rvalid |=>
      q.trim == $past(sig_rdata[15:8]) && q.state == ST_RST_DELAY)
    else $error("trim not loaded from signature high byte");

  a_rc_decode: assert property (
    q.state == ST_RUN && q.fuse.src == SRC_RC_8M |=>
      q.rc_sel && q.nominal_mhz == 4'h8 && !q.ext_sel)
    else $error("rc source decode wrong");

  a_ext_decode: assert property (
    q.state == ST_RUN && q.fuse.src == SRC_EXT |=> q.ext_sel && !q.rc_sel)
    else $error("external clock decode wrong");

  a_wake_six: assert property (
    q.state == ST_RUN && wake_req |=> s_wake_hold ##1 s_wake_done)
    else $error("wake-up start-up not six cycles");

  a_delay_ticks: assert property (
    q.state == ST_RST_DELAY && dly_busy && !wdt_tick && u_rst_delay.q.rem != '0
      |=> q.state == ST_RST_DELAY && $stable(u_rst_delay.q.rem))
    else $error("reset delay advanced without watchdog tick");

  a_trim_write: assert property (
    !q.waitreq && avl_req.write && avl_req.address == ADDR_TRIM &&
      avl_req.byteenable[0] |=> rc_trim == $past(avl_req.writedata[7:0]))
    else $error("trim write not applied");

  a_span_top: assert property (
    q.trim == 8'hff |-> span_min == SPAN_MAX_BASE && span_max == 8'hc8)
    else $error("span at top trim wrong");

  a_span_mid: assert property (
    q.trim == TRIM_MID |-> span_min == 8'h4b && span_max == 8'h96)
    else $error("span at mid trim wrong");

  a_pins_nvm: assert property (
    q.state == ST_RUN && $stable(q.fuse) |=>
      osc_pins_free == rc_select && nvm_timing_rc == rc_select)
    else $error("pin or nvm timing select differs from rc select");

  a_shipped_fuse: assert property (
    q.state == ST_LOAD_REQ && fuses_blank |=>
      q.fuse.src == SRC_RC_1M && q.fuse.startup_time_fuses == SUT_LONG)
    else $error("blank fuses not read as shipped setting");

  a_bus_answer: assert property (
    q.waitreq && bus_req && !loading |=> !avl_waitrequest ##1 avl_waitrequest)
    else $error("bus answer not one cycle");

  a_bus_refused: assert property (
    q.waitreq && loading |=> avl_waitrequest)
    else $error("bus answered during trim load");

  a_sig_hold: assert property (
    q.sig_rd && !sig_rvalid |=> sig_rd)
    else $error("signature read dropped before answer");

  a_ready_load: assert property (
    loading |-> !q.clk_ready)
    else $error("clock ready during trim load");

  a_delay_done: assert property (
    q.state == ST_RST_DELAY && dly_done |=> clk_ready)
    else $error("clock ready missing after reset delay");

  a_rc_one: assert property (
    q.state == ST_RUN && q.fuse.src == SRC_RC_1M |=>
      rc_select && nominal_mhz == 4'h1)
    else $error("rc one mhz decode wrong");

  a_ext_nominal: assert property (
    q.state == ST_RUN && q.fuse.src == SRC_EXT |=> nominal_mhz == 4'h0)
    else $error("external clock shows rc nominal");

  a_span_bottom: assert property (
    q.trim == 8'h00 |-> span_min == SPAN_MIN_BASE &&
      span_max == SPAN_MAX_BASE)
    else $error("span at bottom trim wrong");

  a_trim_masked: assert property (
    !q.waitreq && avl_req.write && !avl_req.byteenable[0] |=>
      $stable(q.trim))
    else $error("trim changed by masked write");

  a_trim_read: assert property (
    q.waitreq && avl_req.read && avl_req.address == ADDR_TRIM && !loading
      |=> avl_readdata[7:0] == rc_trim)
    else $error("trim read data wrong");

  a_wake_idle: assert property (
    loading && wake_req |=> q.state != ST_WAKE)
    else $error("wake honoured before start-up");

endmodule : clock_select_top
`default_nettype wire

// File: test/sig_row_model.sv
// signature row and watchdog oscillator stand-in for the clock select block
`timescale 1ns/1ps
`default_nettype none
module sig_row_model #(
  parameter int LAT = 3,
  parameter int TICK_DIV = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sig_rd,
  input wire logic [7:0] sig_addr,
  input wire logic [7:0] cal_byte,
  output logic sig_rvalid,
  output logic [15:0] sig_rdata,
  output logic wdt_tick
);
  int wait_n = 0;
  int div_n = 0;
  initial begin
    sig_rvalid = 1'b0;
    sig_rdata = 16'h5a5a;
    wdt_tick = 1'b0;
  end
  // ----------------------------------------------------------------
  // row read, answered after LAT+1 cycles
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    sig_rvalid <= 1'b0;
    sig_rdata <= ~sig_rdata; // no stale data outside the answer
    if (sys_rst) begin
      wait_n <= 0;
    end else if (sig_rd && !sig_rvalid) begin
      if (wait_n == LAT) begin
        wait_n <= 0;
        sig_rvalid <= 1'b1;
        sig_rdata <= (sig_addr == 8'h00) ? {cal_byte, 8'ha5} : 16'h0000;
      end else begin
        wait_n <= wait_n + 1;
      end
    end
  end
  // ----------------------------------------------------------------
  // free running watchdog oscillator ticks
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    div_n <= (div_n == TICK_DIV - 1) ? 0 : div_n + 1;
    wdt_tick <= (div_n == TICK_DIV - 1);
  end
endmodule : sig_row_model
`default_nettype wire

// File: test/rc_oscillator_clock_select_trim_bench.sv
// self-checking bench for clock select and rc trim
`timescale 1ns/1ps
`default_nettype none
module rc_oscillator_clock_select_trim_bench import clock_select_pkg::*;;
  localparam int TDIV = 8;
  logic clk_sys, sys_rst, clk_en, fuses_blank, wdt_tick, wake_req;
  avl_req_s avl_req;
  fuse_s fuses;
  logic avl_waitrequest, sig_rd, sig_rvalid, clk_ready, rd_busy;
  logic rc_select, ext_clk_select, osc_pins_free, nvm_timing_rc;
  logic [31:0] avl_readdata, seed, v;
  logic [7:0] sig_addr, rc_trim, cal_byte;
  logic [15:0] sig_rdata;
  logic [3:0] nominal_mhz;
  logic [31:0] exp_q[$];
  int n_errors, checks, i, n;

  clock_select_top #(.RST_SHORT_CNT(4), .RST_LONG_CNT(8)) uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .avl_req(avl_req), .avl_waitrequest(avl_waitrequest),
    .avl_readdata(avl_readdata), .fuses(fuses), .fuses_blank(fuses_blank),
    .wdt_tick(wdt_tick), .wake_req(wake_req), .sig_rd(sig_rd),
    .sig_addr(sig_addr), .sig_rvalid(sig_rvalid), .sig_rdata(sig_rdata),
    .rc_trim(rc_trim), .rc_select(rc_select),
    .ext_clk_select(ext_clk_select), .nominal_mhz(nominal_mhz),
    .osc_pins_free(osc_pins_free), .nvm_timing_rc(nvm_timing_rc),
    .clk_ready(clk_ready));

  sig_row_model #(.LAT(3), .TICK_DIV(TDIV)) row (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sig_rd(sig_rd),
    .sig_addr(sig_addr), .cal_byte(cal_byte), .sig_rvalid(sig_rvalid),
    .sig_rdata(sig_rdata), .wdt_tick(wdt_tick));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // avalon master: hold until waitrequest low is sampled
  // ----------------------------------------------------------------
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int k;
    avl_req <= '{read: !wr, write: wr, address: a, writedata: d,
                 byteenable: be};
    rd_busy <= !wr;
    for (k = 0; k < 300; k++) begin
      @(posedge clk_sys);
      if (avl_waitrequest === 1'b0) break;
    end
    avl_req <= '0;
    rd_busy <= 1'b0;
    if (k == 300) begin
      n_errors++;
      finish_test();
    end
    @(posedge clk_sys);
  endtask : bus

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0, 4'h0);
  endtask : rd

  always @(posedge clk_sys) begin
    if (rd_busy && avl_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) check("read_queue", 32'h1, 32'h0);
      else check("readdata", exp_q.pop_front(), avl_readdata);
    end
  end

  // ----------------------------------------------------------------
  // reset with given fuses, then start-up, selects and registers
  // ----------------------------------------------------------------
  task automatic boot(input logic [3:0] s, input logic [1:0] t,
                      input logic o, input logic b);
    int k, ticks;
    logic rc, ext;
    seed = xs(seed);
    cal_byte <= seed[7:0];
    fuses <= '{src: s, startup_time_fuses: t, opt: o};
    fuses_blank <= b;
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    if (b) begin
      s = 4'h1;
      t = 2'h2;
      o = 1'b1;
    end
    ticks = (t == 2'h1) ? 4 : (t == 2'h2) ? 8 : 0;
    for (k = 0; k < 400; k++) begin
      @(posedge clk_sys);
      if (clk_ready === 1'b1) break;
    end
    check("startup", 1, 32'(k >= (ticks - 1) * TDIV && k <= ticks * TDIV + 30));
    rc = (s >= 4'h1 && s <= 4'h4);
    ext = (s == 4'h0);
    check("selects", {rc, ext, rc, rc, rc ? 4'(1 << (s - 1)) : 4'h0},
          {rc_select, ext_clk_select, osc_pins_free, nvm_timing_rc, nominal_mhz});
    rd(ADDR_TRIM, {24'h0, cal_byte});
    rd(ADDR_STATUS, {20'h0, rc & !o, 1'b0, t == 2'h3, 1'b1, ext, rc, t, s});
  endtask : boot

  initial begin
    seed = 32'd49984;
    n_errors = 0;
    checks = 0;
    clk_en = 1'b1;
    sys_rst = 1'b1;
    wake_req = 1'b0;
    rd_busy = 1'b0;
    avl_req = '0;
    fuses = '0;
    fuses_blank = 1'b0;
    cal_byte = 8'h00;
    for (i = 0; i < 7; i++) boot(i[3:0], i[1:0], i[0], 1'b0);
    boot(4'h9, 2'h3, 1'b0, 1'b1);
    wake_req <= 1'b1;
    @(posedge clk_sys);
    wake_req <= 1'b0;
    n = 0;
    repeat (12) begin
      @(posedge clk_sys);
      if (clk_ready === 1'b0) n++;
    end
    check("wake_len", 6, n);
    seed = xs(seed);
    v = {24'h0, seed[7:0]};
    bus(1'b1, ADDR_TRIM, {seed[31:16], seed[15:0]}, 4'hf);
    @(posedge clk_sys);
    check("rc_trim", v, {24'h0, rc_trim});
    rd(ADDR_TRIM, v);
    bus(1'b1, ADDR_TRIM, ~v, 4'he);
    rd(ADDR_TRIM, v);
    bus(1'b1, ADDR_STATUS, 32'hffff_ffff, 4'hf);
    rd(ADDR_STATUS, {20'h0, 12'h161});
    rd(4'hc, 32'h0);
    bus(1'b1, ADDR_TRIM, 32'h0, 4'h1);
    rd(ADDR_SPAN, 32'h6432);
    bus(1'b1, ADDR_TRIM, 32'h7f, 4'h1);
    rd(ADDR_SPAN, 32'h964b);
    bus(1'b1, ADDR_TRIM, 32'hff, 4'h1);
    rd(ADDR_SPAN, 32'hc864);
    repeat (3) @(posedge clk_sys);
    check("queue_empty", 0, exp_q.size());
    finish_test();
  end
endmodule : rc_oscillator_clock_select_trim_bench
`default_nettype wire
